/* File: ext_bus_ctrl.sv */
`timescale 1ns/10ps
`include "ext_bus_regs.svh"
module ext_bus_ctrl
  import ext_bus_pkg::*;
#(
  parameter int WS_W = 3
) (
  input  wire logic            ref_clk_in,
  input  wire logic            nrst_in,
  input  wire logic            device_reset_n_in,
  output logic                 device_reset_n_out,
  output logic                 device_reset_n_oe_out,
  input  wire logic            watchdog_overflow_in,
  input  wire logic            power_down_in,
  input  wire logic            emulator_float_n_in,
  input  wire logic            external_interface_enable_in,
  input  wire logic            boot_source_select_in,
  input  wire logic [WS_W-1:0] wait_state_count_in,
  input  wire logic            ready_in,
  input  wire logic            req_valid_in,
  input  wire bus_req_t        req_in,
  output logic                 req_ready_out,
  output logic                 done_out,
  output logic [15:0]          rdata_out,
  output logic                 illegal_address_out,
  input  wire logic [15:0]     data_in,
  output logic [15:0]          data_out,
  output logic                 data_oe_out,
  output bus_pins_t            pins_out,
  output bus_pins_t            pins_oe_out,
  input  wire logic            trace_mode_enable_in,
  input  wire logic            trace_mode_disable_in,
  input  wire logic [15:0]     trace_data_in,
  output logic                 bus_trace_mode_out,
  output logic                 trace_bus_drive_n_out,
  output logic                 trace_bus_clock_out,
  output logic                 cpu_clock_output_out,
  input  wire logic [15:0]     pc_next_in,
  output logic [15:0]          program_counter_out,
  output logic                 exec_start_out,
  output logic                 boot_external_out
);

  // ********************************************
  // Reset pin and watchdog pulse
  // ********************************************
  logic [3:0] wd_cnt_q;
  logic       rst_active;
  logic       rst_active_q;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wd_cnt_q <= `WD_CNT_ZERO;
    end else if (watchdog_overflow_in && wd_cnt_q == `WD_CNT_ZERO) begin
      wd_cnt_q <= `WD_PULSE_CYCLES;
    end else if (wd_cnt_q != `WD_CNT_ZERO) begin
      wd_cnt_q <= wd_cnt_q - 4'h1;
    end
  end

  assign device_reset_n_out    = 1'b0;
  assign device_reset_n_oe_out = (wd_cnt_q != `WD_CNT_ZERO);
  assign rst_active = !device_reset_n_in || device_reset_n_oe_out;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_active_q <= 1'b1;
    end else begin
      rst_active_q <= rst_active;
    end
  end

  // ********************************************
  // Program counter and boot source
  // ********************************************
  logic [15:0] pc_q;
  logic        boot_ext_q;
  logic        exec_start_q;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_q <= `RESET_VECTOR;
    end else if (rst_active) begin
      pc_q <= `RESET_VECTOR;
    end else if (!rst_active_q) begin
      pc_q <= pc_next_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      exec_start_q <= 1'b0;
    end else begin
      exec_start_q <= rst_active_q && !rst_active;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_ext_q <= `BOOT_RESET;
    end else if (rst_active || rst_active_q) begin
      boot_ext_q <= boot_source_select_in;
    end
  end

  assign program_counter_out = pc_q;
  assign exec_start_out      = exec_start_q;
  assign boot_external_out   = boot_ext_q;

  // ********************************************
  // Trace mode
  // ********************************************
  logic trace_q;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trace_q <= `TRACE_MODE_RESET;
    end else if (rst_active) begin
      trace_q <= `TRACE_MODE_RESET;
    end else if (trace_mode_disable_in) begin
      trace_q <= 1'b0;
    end else if (trace_mode_enable_in) begin
      trace_q <= 1'b1;
    end
  end

  assign bus_trace_mode_out   = trace_q;
  assign trace_bus_clock_out  = ref_clk_in;
  assign cpu_clock_output_out = ref_clk_in;

  // ********************************************
  // Bus cycle sequencer
  // ********************************************
  bus_state_t      state_q;
  bus_state_t      state_d;
  bus_req_t        req_q;
  bus_req_t        cur_req;
  logic [WS_W-1:0] ws_cnt_q;
  logic [WS_W-1:0] ws_cfg_q;
  logic            accept;
  logic            illegal_q;
  logic            done_q;
  logic            in_cycle;

  assign req_ready_out = (state_q == ST_IDLE) && !rst_active;
  assign accept        = req_valid_in && req_ready_out;
  assign cur_req       = accept ? req_in : req_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (accept && external_interface_enable_in) begin
          state_d = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (ws_cnt_q > `WS_CNT_ONE) begin
          state_d = ST_ACCESS;
        end else if (ws_cfg_q != `WS_CNT_ZERO && !ready_in) begin
          state_d = ST_WAIT;
        end else begin
          state_d = ST_DONE;
        end
      end
      ST_WAIT: begin
        if (ready_in) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (rst_active) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_q    <= '0;
      ws_cfg_q <= `WS_CNT_ZERO;
    end else if (accept) begin
      req_q    <= req_in;
      ws_cfg_q <= wait_state_count_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ws_cnt_q <= `WS_CNT_ZERO;
    end else if (accept) begin
      ws_cnt_q <= wait_state_count_in;
    end else if (state_q == ST_ACCESS && ws_cnt_q != `WS_CNT_ZERO) begin
      ws_cnt_q <= ws_cnt_q - `WS_CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= accept && !external_interface_enable_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_d == ST_DONE) || (accept && !external_interface_enable_in);
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= `DATA_RESET;
    end else if (state_d == ST_DONE && !req_q.write) begin
      rdata_out <= data_in;
    end
  end

  assign illegal_address_out = illegal_q;
  assign done_out            = done_q;
  assign in_cycle = (state_d == ST_ACCESS) || (state_d == ST_WAIT);

  // ********************************************
  // Strobe outputs
  // ********************************************
  bus_pins_t pins_q;
  bus_pins_t oe_q;
  logic      sel_float;
  logic      emu_float;

  assign emu_float = !emulator_float_n_in;
  assign sel_float = rst_active || power_down_in || emu_float;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pins_q <= '1;
    end else begin
      pins_q <= '1;
      if (in_cycle) begin
        pins_q.io_space_select_n      <= cur_req.space != SPACE_IO;
        pins_q.data_space_select_n    <= cur_req.space != SPACE_DATA;
        pins_q.program_space_select_n <= cur_req.space != SPACE_PROG;
        pins_q.write_strobe_n         <= !cur_req.write;
        pins_q.read_strobe_n          <= cur_req.write;
        pins_q.read_write             <= !cur_req.write;
        pins_q.external_access_strobe_n <= 1'b0;
        pins_q.global_memory_request_n <=
          !(cur_req.global_mem && cur_req.space == SPACE_DATA);
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      oe_q <= '0;
    end else begin
      oe_q.io_space_select_n        <= !sel_float;
      oe_q.data_space_select_n      <= !sel_float;
      oe_q.program_space_select_n   <= !sel_float;
      oe_q.write_strobe_n           <= !emu_float;
      oe_q.read_strobe_n            <= !emu_float;
      oe_q.read_write               <= !emu_float && !power_down_in;
      oe_q.external_access_strobe_n <= !emu_float && !power_down_in;
      oe_q.global_memory_request_n  <= !sel_float;
    end
  end

  assign pins_out    = pins_q;
  assign pins_oe_out = oe_q;

  // ********************************************
  // Data bus drive
  // ********************************************
  logic [15:0] data_q;
  logic        data_oe_q;
  logic        drive_n_q;
  logic        wr_drive;
  logic        rd_cycle;
  logic        oe_d;

  assign wr_drive = in_cycle && cur_req.write;
  assign rd_cycle = in_cycle && !cur_req.write;
  assign oe_d     = wr_drive || (trace_q && !rd_cycle);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_q    <= `DATA_RESET;
      data_oe_q <= 1'b0;
      drive_n_q <= 1'b1;
    end else begin
      data_oe_q <= oe_d;
      drive_n_q <= !(trace_q && oe_d);
      if (wr_drive) begin
        data_q <= cur_req.wdata;
      end else if (trace_q) begin
        data_q <= trace_data_in;
      end
    end
  end

  assign data_out              = data_q;
  assign data_oe_out           = data_oe_q;
  assign trace_bus_drive_n_out = drive_n_q;

endmodule // ext_bus_ctrl

/* File: ext_bus_regs.svh */
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

// ********************************************
// Reset values and constants
// ********************************************
`define RESET_VECTOR      16'h0000
`define WD_PULSE_CYCLES   4'h8
`define WD_CNT_ZERO       4'h0
`define WS_CNT_ZERO       3'h0
`define WS_CNT_ONE        3'h1
`define TRACE_MODE_RESET  1'b1
`define BOOT_RESET        1'b0
`define DATA_RESET        16'h0000

`endif

/* File: ext_bus_pkg.sv */
package ext_bus_pkg;

  // ********************************************
  // Types
  // ********************************************
  typedef enum logic [1:0] {
    SPACE_PROG = 2'h0,
    SPACE_DATA = 2'h1,
    SPACE_IO   = 2'h2
  } space_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ACCESS = 4'h2,
    ST_WAIT   = 4'h4,
    ST_DONE   = 4'h8
  } bus_state_t;

  typedef struct packed {
    logic        write;
    space_t      space;
    logic        global_mem;
    logic [15:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic io_space_select_n;
    logic data_space_select_n;
    logic program_space_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic read_write;
    logic external_access_strobe_n;
    logic global_memory_request_n;
  } bus_pins_t;

endpackage

/* File: ext_bus_ctrl_sva.sv */
`timescale 1ns/10ps
// ********
// Pin checks
// ********
// Pin bits 7..0: io, data, prog select, write, read, dir, strobe, global
module ext_bus_ctrl_sva
  import ext_bus_pkg::*;
(
  input wire logic      ref_clk_in,
  input wire logic      nrst_in,
  input wire logic      device_reset_n_oe_out,
  input wire logic      emulator_float_n_in,
  input wire logic      external_interface_enable_in,
  input wire logic      req_valid_in,
  input wire logic      req_ready_out,
  input wire logic      ready_in,
  input wire logic      done_out,
  input wire logic      illegal_address_out,
  input wire logic      data_oe_out,
  input wire bus_pins_t pins_out,
  input wire bus_pins_t pins_oe_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  AST_SEL_IDLE:
    assert property (req_ready_out |-> pins_out[7:5] == 3'h7) else $error("select low idle");
  AST_GLOBAL_DATA:
    assert property (!pins_out[0] |-> !pins_out[6]) else $error("global outside data");
  AST_READ_STROBE:
    assert property (!pins_out[3] |-> !pins_out[1] && pins_out[2]) else $error("bad read");
  AST_WRITE_DRIVE:
    assert property (!pins_out[4] |-> !pins_out[1] && !pins_out[2] && data_oe_out)
      else $error("bad write");
  AST_DIR_READ:
    assert property (pins_out[4] |-> pins_out[2]) else $error("direction low");
  AST_EMU_FLOAT:
    assert property (!emulator_float_n_in |=> pins_oe_out == 8'h00) else $error("driven in float");
  AST_DONE_RELEASE:
    assert property ($rose(pins_out[1]) |-> done_out) else $error("strobe end without done");
  AST_ILLEGAL:
    assert property (req_valid_in && req_ready_out && !external_interface_enable_in
      |=> illegal_address_out && done_out && pins_out[1]) else $error("no illegal flag");
  AST_WD_PULSE:
    assert property ($rose(device_reset_n_oe_out) |-> device_reset_n_oe_out[*8]
      ##1 !device_reset_n_oe_out) else $error("reset pulse not eight");
  cover property (!ready_in && !pins_out[1]);
  cover property (illegal_address_out);
  cover property ($rose(device_reset_n_oe_out));
endmodule // ext_bus_ctrl_sva

bind ext_bus_ctrl ext_bus_ctrl_sva i_ext_bus_ctrl_sva (
  .ref_clk_in                   (ref_clk_in),
  .nrst_in                      (nrst_in),
  .device_reset_n_oe_out        (device_reset_n_oe_out),
  .emulator_float_n_in          (emulator_float_n_in),
  .external_interface_enable_in (external_interface_enable_in),
  .req_valid_in                 (req_valid_in),
  .req_ready_out                (req_ready_out),
  .ready_in                     (ready_in),
  .done_out                     (done_out),
  .illegal_address_out          (illegal_address_out),
  .data_oe_out                  (data_oe_out),
  .pins_out                     (pins_out),
  .pins_oe_out                  (pins_oe_out)
);

/* File: ext_mem_model.sv */
`timescale 1ns/10ps
// ********
// External memory
// ********
module ext_mem_model
  import ext_bus_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire bus_pins_t   pins_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        drive_in,
  input  wire logic [3:0]  slow_in,
  output logic [15:0]      rdata_out,
  output logic             ready_out
);
  logic [15:0] mem_q [3];
  logic [15:0] last_q = 16'h0000;
  logic [3:0]  cnt_q = 4'h0;
  logic [1:0]  sp;
  assign sp = !pins_in[7] ? 2'h2 : (!pins_in[6] ? 2'h1 : 2'h0);
  assign ready_out = pins_in[1] || cnt_q >= slow_in;
  assign rdata_out = !pins_in[3] ? mem_q[sp] : ~last_q;
  always_ff @(posedge ref_clk_in) begin
    last_q <= rdata_out;
    cnt_q <= pins_in[1] ? 4'h0 : cnt_q + 4'h1;
    if (!pins_in[4] && drive_in) begin
      mem_q[sp] <= wdata_in;
    end
  end
endmodule // ext_mem_model

/* File: external_memory_bus_control_bench.sv */
`timescale 1ns/10ps
// ********
// Bench
// ********
module external_memory_bus_control_bench
  import ext_bus_pkg::*;
;
  logic        ref_clk_in, nrst_in, device_reset_n_in, device_reset_n_out;
  logic        device_reset_n_oe_out, watchdog_overflow_in, power_down_in;
  logic        emulator_float_n_in, external_interface_enable_in, boot_source_select_in;
  logic        ready_in, req_valid_in, req_ready_out, done_out, illegal_address_out;
  logic        data_oe_out, trace_mode_enable_in, trace_mode_disable_in;
  logic        bus_trace_mode_out, trace_bus_drive_n_out, trace_bus_clock_out;
  logic        cpu_clock_output_out, exec_start_out, boot_external_out;
  logic [2:0]  wait_state_count_in;
  logic [3:0]  slow;
  logic [15:0] rdata_out, data_in, data_out, trace_data_in, pc_next_in, program_counter_out;
  bus_req_t    req_in;
  bus_pins_t   pins_out, pins_oe_out;
  int          fails, n_checks;
  ext_bus_ctrl i_ext_bus_ctrl (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .device_reset_n_in(device_reset_n_in),
    .device_reset_n_out(device_reset_n_out), .device_reset_n_oe_out(device_reset_n_oe_out),
    .watchdog_overflow_in(watchdog_overflow_in), .power_down_in(power_down_in),
    .emulator_float_n_in(emulator_float_n_in),
    .external_interface_enable_in(external_interface_enable_in),
    .boot_source_select_in(boot_source_select_in),
    .wait_state_count_in(wait_state_count_in), .ready_in(ready_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
    .done_out(done_out), .rdata_out(rdata_out), .illegal_address_out(illegal_address_out),
    .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out),
    .pins_out(pins_out), .pins_oe_out(pins_oe_out),
    .trace_mode_enable_in(trace_mode_enable_in), .trace_mode_disable_in(trace_mode_disable_in),
    .trace_data_in(trace_data_in), .bus_trace_mode_out(bus_trace_mode_out),
    .trace_bus_drive_n_out(trace_bus_drive_n_out), .trace_bus_clock_out(trace_bus_clock_out),
    .cpu_clock_output_out(cpu_clock_output_out), .pc_next_in(pc_next_in),
    .program_counter_out(program_counter_out), .exec_start_out(exec_start_out),
    .boot_external_out(boot_external_out));
  ext_mem_model i_ext_mem_model (.ref_clk_in, .pins_in(pins_out), .wdata_in(data_out),
    .drive_in(data_oe_out), .slow_in(slow), .rdata_out(data_in), .ready_out(ready_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic xfer(input logic w, input space_t sp, input logic [15:0] wd,
                      output int lat, output logic ill);
    req_valid_in <= 1'b1;
    req_in <= '{write: w, space: sp, global_mem: sp == SPACE_DATA, wdata: wd};
    @(negedge ref_clk_in);
    while (req_ready_out !== 1'b1) @(negedge ref_clk_in);
    @(posedge ref_clk_in);
    req_valid_in <= 1'b0;
    lat = 0;
    do begin
      @(negedge ref_clk_in);
      lat++;
    end while (done_out !== 1'b1 && lat < 30);
    ill = illegal_address_out;
    @(posedge ref_clk_in);
  endtask
  task automatic t_traffic(input logic [2:0] ws, input logic [3:0] slw);
    int lat;
    logic ill;
    int nst = (ws == 3'h0) ? 1 : ((int'(slw) + 1 > int'(ws)) ? int'(slw) + 1 : int'(ws));
    wait_state_count_in <= ws;
    slow <= slw;
    for (int s = 0; s < 3; s++) begin
      xfer(1'b1, space_t'(s), 16'hA5C0 + 16'(s), lat, ill);
      chk("write latency", 16'(nst + 1), 16'(lat));
      xfer(1'b0, space_t'(s), 16'h0000, lat, ill);
      chk("read latency", 16'(nst + 1), 16'(lat));
      chk("read data", 16'hA5C0 + 16'(s), rdata_out);
    end
  endtask
  task automatic t_illegal;
    int lat;
    logic ill;
    external_interface_enable_in <= 1'b0;
    xfer(1'b0, SPACE_IO, 16'h0000, lat, ill);
    chk("illegal", 16'h0001, 16'(ill));
    chk("illegal latency", 16'h0001, 16'(lat));
    external_interface_enable_in <= 1'b1;
  endtask
  task automatic t_float;
    emulator_float_n_in <= 1'b0;
    tick(2);
    chk("float oe", 16'h0000, 16'(pins_oe_out));
    emulator_float_n_in <= 1'b1;
    power_down_in <= 1'b1;
    tick(2);
    chk("pdown oe", 16'h0000, 16'(pins_oe_out & 8'hE7));
    power_down_in <= 1'b0;
    tick(2);
    chk("strobe oe", 16'h0001, 16'(pins_oe_out[1]));
  endtask
  task automatic t_trace;
    trace_mode_disable_in <= 1'b1;
    tick(1);
    trace_mode_disable_in <= 1'b0;
    tick(3);
    chk("trace off", 16'h0000, 16'(bus_trace_mode_out));
    chk("bus released", 16'h0000, 16'(data_oe_out));
    chk("drive ind", 16'h0001, 16'(trace_bus_drive_n_out));
  endtask
  task automatic t_wd;
    int n;
    n = 0;
    watchdog_overflow_in <= 1'b1;
    tick(1);
    watchdog_overflow_in <= 1'b0;
    repeat (12) begin
      @(negedge ref_clk_in);
      n += int'(device_reset_n_oe_out === 1'b1);
    end
    tick(1);
    chk("pulse cycles", 16'h0008, 16'(n));
    chk("pulse level", 16'h0000, 16'(device_reset_n_out));
    chk("trace again", 16'h0001, 16'(bus_trace_mode_out));
  endtask
  task automatic t_boot;
    boot_source_select_in <= 1'b1;
    device_reset_n_in <= 1'b0;
    tick(3);
    chk("pc reset", 16'h0000, program_counter_out);
    device_reset_n_in <= 1'b1;
    tick(1);
    @(negedge ref_clk_in);
    chk("exec start", 16'h0001, 16'(exec_start_out));
    chk("pc at start", 16'h0000, program_counter_out);
    tick(2);
    chk("boot ext", 16'h0001, 16'(boot_external_out));
  endtask
  initial begin
    fails = 0;
    n_checks = 0;
    nrst_in = 1'b0;
    device_reset_n_in = 1'b1;
    watchdog_overflow_in = 1'b0;
    power_down_in = 1'b0;
    emulator_float_n_in = 1'b1;
    external_interface_enable_in = 1'b1;
    boot_source_select_in = 1'b0;
    wait_state_count_in = 3'h1;
    req_valid_in = 1'b0;
    req_in = '0;
    trace_mode_enable_in = 1'b0;
    trace_mode_disable_in = 1'b0;
    trace_data_in = 16'h5A3C;
    pc_next_in = 16'h1234;
    slow = 4'h0;
    tick(12);
    nrst_in <= 1'b1;
    tick(3);
    chk("pins idle", 16'h00FF, 16'(pins_out));
    chk("trace on", 16'h0001, 16'(bus_trace_mode_out));
    chk("boot int", 16'h0000, 16'(boot_external_out));
    chk("trace bus oe", 16'h0001, 16'(data_oe_out));
    chk("trace data", 16'h5A3C, data_out);
    chk("drive ind on", 16'h0000, 16'(trace_bus_drive_n_out));
    #2;
    chk("trace clk", 16'h0001, 16'(trace_bus_clock_out));
    chk("cpu clk", 16'h0001, 16'(cpu_clock_output_out));
    tick(1);
    t_traffic(3'h1, 4'h0);
    t_traffic(3'h0, 4'h3);
    t_traffic(3'h2, 4'h4);
    t_illegal;
    t_float;
    t_trace;
    t_wd;
    t_boot;
    tally_and_finish;
  end
  initial begin
    tick(3000);
    fails++;
    tally_and_finish;
  end
endmodule // external_memory_bus_control_bench
